// file: src/iwpmc_ctrl.v
// Interrupt, clock-select and power-mode controller for a small core
`timescale 1ns/100ps
`include "iwpmc_defs.vh"

// How it works
// - Trap op vectors to soft vector whatever the global enable, and clears it.
// - Enable and return ops set the global enable; mask op clears it.
// - Each event sets its pending bit; only a written 0 clears it.
// - Pending, enabled and globally enabled: vector to hardware vector, clear enable.
// - Pending bits read back as set only where their enable bit is 1.
// - Timer-0 flag sets when the 8-bit up counter wraps its ends.
// - Timer-1 flag sets when the 10-bit down counter underflows.
// - Watchdog timeout sets its flag only when configured for interrupt.
// - Level change on an input pin with wake enable sets pin-change flag.
// - Pin 0 change detection is off while external interrupt is selected.
// - Chosen edge on pin 0 sets the external flag when selected.
// - Falling low-voltage detector output sets the low-voltage flag.
// - Rising touch compare sets its flag; touch overflow sets its own.
// - Clock select picks fast or slow; instruction clock divides by 2 or 4.
// - Stop bit stops fast oscillator, accepted only once already on slow clock.
// - After reset start in Normal or Slow by startup-clock configuration.
// - Standby code halts execution; slow osc and enabled timers keep running.
// - Halt entered by sleep op or by writing the halt code.
// - Entering Halt clears power-down bit, sets timeout bit, clears watchdog.
// - Halt stops execution, peripherals, timers and both oscillators.
// - Wake sources differ for Standby and Halt; resume per clock select.
// - Halt wake waits 16 system clocks; Standby none; then vector if enabled.
module iwpmc_ctrl (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_ce,
  input wire [4:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  input wire i_instr_boundary,
  input wire i_op_trap,
  input wire i_op_enable,
  input wire i_op_mask,
  input wire i_op_return,
  input wire i_op_sleep,
  input wire [7:0] i_timer0_count,
  input wire [9:0] i_timer1_count,
  input wire i_wdt_timeout,
  input wire [5:0] i_pin_is_input,
  input wire [5:0] i_port_pin,
  input wire i_lvd_out,
  input wire i_touch_compare_out,
  input wire i_touch_overflow,
  output reg o_vector_load,
  output reg [10:0] o_vector_addr,
  output reg o_exec_run,
  output reg o_periph_enable,
  output reg o_timer_enable,
  output reg o_fast_rc_osc_en,
  output reg o_slow_rc_osc_en,
  output reg o_sys_clk_fast,
  output reg o_inst_div4,
  output reg o_wdt_clear,
  output reg o_global_irq_enable
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg [2:0] state;
  reg [2:0] next_state;
  reg [4:0] settle_cnt;
  reg [7:0] pending_flag_reg;
  reg [7:0] irq_enable_reg;
  reg fast_clock_select;
  reg fast_osc_stop;
  reg [5:0] pin_wake_enable;
  reg ext_irq_select;
  reg ext_edge_select;
  reg [2:0] cfg_bits;
  reg power_down_status_n;
  reg watchdog_expired_n;
  reg [7:0] t0_prev;
  reg [9:0] t1_prev;
  reg [5:0] pin_meta;
  reg [5:0] pin_sync;
  reg [5:0] pin_prev;
  reg lvd_meta;
  reg lvd_sync;
  reg lvd_prev;
  reg tcmp_meta;
  reg tcmp_sync;
  reg tcmp_prev;

  wire bus_req;
  wire wr_ok;
  wire running;
  wire [7:0] live;
  wire [5:0] pin_chg;
  wire ext_edge;
  wire [7:0] flag_set;
  wire [7:0] wake_hit_sb;
  wire [7:0] wake_hit_halt;
  wire [1:0] pm_req;

  // ---------------------------------------------------------------
  // Bus strobes: one wait state, access completes on the low cycle
  // ---------------------------------------------------------------
  assign bus_req = i_avs_read | i_avs_write;
  assign wr_ok = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  assign running = (state == `IWPMC_ST_NORMAL) | (state == `IWPMC_ST_SLOW);
  assign live = pending_flag_reg & irq_enable_reg;
  assign pm_req = i_avs_writedata[`IWPMC_B_PMODE_HI:`IWPMC_B_PMODE_LO];

  // ---------------------------------------------------------------
  // Pin synchronisers; first stage feeds only the second
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      pin_meta <= 6'h00;
      pin_sync <= 6'h00;
      pin_prev <= 6'h00;
      lvd_meta <= 1'b1;
      lvd_sync <= 1'b1;
      lvd_prev <= 1'b1;
      tcmp_meta <= 1'b0;
      tcmp_sync <= 1'b0;
      tcmp_prev <= 1'b0;
      t0_prev <= 8'h00;
      t1_prev <= 10'h000;
    end else if (i_ce) begin
      pin_meta <= i_port_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      lvd_meta <= i_lvd_out;
      lvd_sync <= lvd_meta;
      lvd_prev <= lvd_sync;
      tcmp_meta <= i_touch_compare_out;
      tcmp_sync <= tcmp_meta;
      tcmp_prev <= tcmp_sync;
      t0_prev <= i_timer0_count;
      t1_prev <= i_timer1_count;
    end
  end

  // ---------------------------------------------------------------
  // Event detection, one set bit per source
  // ---------------------------------------------------------------
  // Pin 0 leaves change detection to the external edge logic while external interrupt is selected
  assign pin_chg = (pin_sync ^ pin_prev) & pin_wake_enable & i_pin_is_input &
                   {5'h1F, ~ext_irq_select};
  // Edge select 1 means rising edge, 0 falling
  assign ext_edge = ext_irq_select & (pin_sync[0] ^ pin_prev[0]) &
                    (pin_sync[0] == ext_edge_select);
  assign flag_set[`IWPMC_B_TIMER0] = (t0_prev == `IWPMC_T0_TOP) &
                                     (i_timer0_count == `IWPMC_T0_BOT);
  assign flag_set[`IWPMC_B_TIMER1] = (t1_prev == `IWPMC_T1_BOT) &
                                     (i_timer1_count == `IWPMC_T1_TOP);
  assign flag_set[`IWPMC_B_PINCHG] = |pin_chg;
  assign flag_set[`IWPMC_B_EXT] = ext_edge;
  assign flag_set[`IWPMC_B_LOWV] = lvd_prev & ~lvd_sync;
  assign flag_set[`IWPMC_B_TCMP] = ~tcmp_prev & tcmp_sync;
  assign flag_set[`IWPMC_B_WDOG] = i_wdt_timeout & cfg_bits[`IWPMC_B_CFG_WDTIRQ];
  assign flag_set[`IWPMC_B_TOVF] = i_touch_overflow;

  // Wake needs the source flagged and its enable set
  assign wake_hit_sb = live & `IWPMC_WAKE_STANDBY;
  assign wake_hit_halt = live & `IWPMC_WAKE_HALT;

  // ---------------------------------------------------------------
  // Pending flags: a set in the clearing cycle wins
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      pending_flag_reg <= 8'h00;
    end else if (i_ce) begin
      if (wr_ok && i_avs_address == `IWPMC_OFF_PENDING) begin
        pending_flag_reg <= (pending_flag_reg & i_avs_writedata[7:0]) | flag_set;
      end else begin
        pending_flag_reg <= pending_flag_reg | flag_set;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software-written control registers
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      irq_enable_reg <= 8'h00;
      fast_osc_stop <= 1'b0;
      pin_wake_enable <= 6'h00;
      ext_irq_select <= 1'b0;
      ext_edge_select <= 1'b0;
      cfg_bits <= `IWPMC_CFG_RESET;
    end else if (i_ce && wr_ok) begin
      case (i_avs_address)
        `IWPMC_OFF_ENABLE: begin
          irq_enable_reg <= i_avs_writedata[7:0];
        end
        `IWPMC_OFF_OSC: begin
          // Stop is refused unless already on slow and staying there
          if (!fast_clock_select && !i_avs_writedata[`IWPMC_B_CLKSEL]) begin
            fast_osc_stop <= i_avs_writedata[`IWPMC_B_FSTOP];
          end else begin
            fast_osc_stop <= 1'b0;
          end
        end
        `IWPMC_OFF_PINCFG: begin
          pin_wake_enable <= i_avs_writedata[5:0];
          ext_irq_select <= i_avs_writedata[`IWPMC_B_EXTSEL];
          ext_edge_select <= i_avs_writedata[`IWPMC_B_EDGE];
        end
        `IWPMC_OFF_CONFIG: begin
          cfg_bits <= i_avs_writedata[2:0];
        end
        default: begin
          cfg_bits <= cfg_bits;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      `IWPMC_ST_START: begin
        next_state = cfg_bits[`IWPMC_B_CFG_SFAST] ? `IWPMC_ST_NORMAL :
                     `IWPMC_ST_SLOW;
      end
      `IWPMC_ST_NORMAL, `IWPMC_ST_SLOW: begin
        if (i_instr_boundary && i_op_sleep) begin
          next_state = `IWPMC_ST_HALT;
        end else if (wr_ok && i_avs_address == `IWPMC_OFF_OSC &&
                     pm_req == `IWPMC_PM_HALT) begin
          next_state = `IWPMC_ST_HALT;
        end else if (wr_ok && i_avs_address == `IWPMC_OFF_OSC &&
                     pm_req == `IWPMC_PM_STANDBY) begin
          next_state = `IWPMC_ST_STANDBY;
        end else if (wr_ok && i_avs_address == `IWPMC_OFF_OSC) begin
          next_state = i_avs_writedata[`IWPMC_B_CLKSEL] ? `IWPMC_ST_NORMAL :
                       `IWPMC_ST_SLOW;
        end
      end
      `IWPMC_ST_STANDBY: begin
        // Clocks still run, so no settling wait
        if (|wake_hit_sb) begin
          next_state = fast_clock_select ? `IWPMC_ST_NORMAL : `IWPMC_ST_SLOW;
        end
      end
      `IWPMC_ST_HALT: begin
        if (|wake_hit_halt) begin
          next_state = `IWPMC_ST_SETTLE;
        end
      end
      `IWPMC_ST_SETTLE: begin
        if (settle_cnt == `IWPMC_WAKE_CYCLES - 5'h01) begin
          next_state = fast_clock_select ? `IWPMC_ST_NORMAL : `IWPMC_ST_SLOW;
        end
      end
      default: begin
        next_state = `IWPMC_ST_START;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= `IWPMC_ST_START;
      settle_cnt <= 5'h00;
      fast_clock_select <= 1'b1;
    end else if (i_ce) begin
      state <= next_state;
      // Count oscillator settling after a halt wake
      if (state == `IWPMC_ST_SETTLE) begin
        settle_cnt <= settle_cnt + 5'h01;
      end else begin
        settle_cnt <= 5'h00;
      end
      if (state == `IWPMC_ST_START) begin
        fast_clock_select <= cfg_bits[`IWPMC_B_CFG_SFAST];
      end else if (running && wr_ok && i_avs_address == `IWPMC_OFF_OSC) begin
        fast_clock_select <= i_avs_writedata[`IWPMC_B_CLKSEL];
      end
    end
  end

  // ---------------------------------------------------------------
  // Status bits and watchdog clear on halt entry
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      power_down_status_n <= 1'b1;
      watchdog_expired_n <= 1'b1;
      o_wdt_clear <= 1'b0;
    end else if (i_ce) begin
      o_wdt_clear <= 1'b0;
      if (next_state == `IWPMC_ST_HALT && state != `IWPMC_ST_HALT) begin
        power_down_status_n <= 1'b0;
        watchdog_expired_n <= 1'b1;
        o_wdt_clear <= 1'b1;
      end else if (i_wdt_timeout) begin
        watchdog_expired_n <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Global enable and vector fetch, only at instruction boundaries
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_global_irq_enable <= 1'b0;
      o_vector_load <= 1'b0;
      o_vector_addr <= `IWPMC_VEC_SOFT;
    end else if (i_ce) begin
      o_vector_load <= 1'b0;
      if (running && i_instr_boundary) begin
        if (i_op_trap) begin
          o_vector_load <= 1'b1;
          o_vector_addr <= `IWPMC_VEC_SOFT;
          o_global_irq_enable <= 1'b0;
        end else if (i_op_mask) begin
          o_global_irq_enable <= 1'b0;
        end else if (o_global_irq_enable && (|live)) begin
          // Also reached after a wake, which gives the handler entry
          o_vector_load <= 1'b1;
          o_vector_addr <= `IWPMC_VEC_HARD;
          o_global_irq_enable <= 1'b0;
        end else if (i_op_enable || i_op_return) begin
          o_global_irq_enable <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock and enable outputs, registered; enables from the next state, clock select and divider from their registers
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_exec_run <= 1'b0;
      o_periph_enable <= 1'b0;
      o_timer_enable <= 1'b0;
      o_fast_rc_osc_en <= 1'b1;
      o_slow_rc_osc_en <= 1'b1;
      o_sys_clk_fast <= 1'b1;
      o_inst_div4 <= 1'b0;
    end else if (i_ce) begin
      o_exec_run <= (next_state == `IWPMC_ST_NORMAL) | (next_state == `IWPMC_ST_SLOW);
      o_periph_enable <= (next_state == `IWPMC_ST_NORMAL) |
                         (next_state == `IWPMC_ST_SLOW);
      o_timer_enable <= (next_state != `IWPMC_ST_HALT) &
                        (next_state != `IWPMC_ST_SETTLE);
      o_fast_rc_osc_en <= ~fast_osc_stop & (next_state != `IWPMC_ST_HALT);
      o_slow_rc_osc_en <= (next_state != `IWPMC_ST_HALT);
      o_sys_clk_fast <= fast_clock_select;
      o_inst_div4 <= cfg_bits[`IWPMC_B_CFG_DIV4];
    end
  end

  // ---------------------------------------------------------------
  // Avalon slave: waitrequest drops one cycle after the request
  // ---------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else if (i_ce) begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        case (i_avs_address)
          `IWPMC_OFF_PENDING: o_avs_readdata <= {24'h000000, live};
          `IWPMC_OFF_ENABLE: o_avs_readdata <= {24'h000000, irq_enable_reg};
          `IWPMC_OFF_OSC: o_avs_readdata <= {28'h0000000, 2'h0, fast_osc_stop,
                                             fast_clock_select};
          `IWPMC_OFF_PINCFG: o_avs_readdata <= {24'h000000, ext_edge_select,
                                                ext_irq_select, pin_wake_enable};
          `IWPMC_OFF_STATUS: o_avs_readdata <= {24'h000000, 2'h0, watchdog_expired_n,
                                                power_down_status_n,
                                                o_global_irq_enable, state};
          `IWPMC_OFF_CONFIG: o_avs_readdata <= {29'h00000000, cfg_bits};
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: src/iwpmc_defs.vh
// Constants for the interrupt, wake-up and power-mode controller
`ifndef IWPMC_DEFS_VH
`define IWPMC_DEFS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define IWPMC_OFF_PENDING 5'h00
`define IWPMC_OFF_ENABLE 5'h04
`define IWPMC_OFF_OSC 5'h08
`define IWPMC_OFF_PINCFG 5'h0C
`define IWPMC_OFF_STATUS 5'h10
`define IWPMC_OFF_CONFIG 5'h14

// ---------------------------------------------------------------
// Flag bit positions (pending and enable registers)
// ---------------------------------------------------------------
`define IWPMC_B_TIMER0 0
`define IWPMC_B_TIMER1 1
`define IWPMC_B_PINCHG 2
`define IWPMC_B_EXT 3
`define IWPMC_B_LOWV 4
`define IWPMC_B_TCMP 5
`define IWPMC_B_WDOG 6
`define IWPMC_B_TOVF 7
`define IWPMC_WAKE_STANDBY 8'hFF
`define IWPMC_WAKE_HALT 8'hEC

// ---------------------------------------------------------------
// Oscillator control, pin config, power-mode codes and config fields
// ---------------------------------------------------------------
`define IWPMC_B_CLKSEL 0
`define IWPMC_B_FSTOP 1
`define IWPMC_B_PMODE_LO 2
`define IWPMC_B_PMODE_HI 3
`define IWPMC_B_EXTSEL 6
`define IWPMC_B_EDGE 7
`define IWPMC_PM_NONE 2'h0
`define IWPMC_PM_HALT 2'h1
`define IWPMC_PM_STANDBY 2'h2
`define IWPMC_B_CFG_WDTIRQ 0
`define IWPMC_B_CFG_DIV4 1
`define IWPMC_B_CFG_SFAST 2
`define IWPMC_CFG_RESET 3'h4

// ---------------------------------------------------------------
// Vectors, counter end values, timing
// ---------------------------------------------------------------
`define IWPMC_VEC_SOFT 11'h001
`define IWPMC_VEC_HARD 11'h008
`define IWPMC_T0_TOP 8'hFF
`define IWPMC_T0_BOT 8'h00
`define IWPMC_T1_TOP 10'h3FF
`define IWPMC_T1_BOT 10'h000
`define IWPMC_WAKE_CYCLES 5'h10

// ---------------------------------------------------------------
// Power state codes
// ---------------------------------------------------------------
`define IWPMC_ST_START 3'h0
`define IWPMC_ST_NORMAL 3'h1
`define IWPMC_ST_SLOW 3'h2
`define IWPMC_ST_STANDBY 3'h3
`define IWPMC_ST_HALT 3'h4
`define IWPMC_ST_SETTLE 3'h5

`endif

// file: testbench/iwpmc_ctrl_bench.sv
// Self-checking bench for the interrupt, wake-up and power-mode controller
`timescale 1ns/100ps
`include "iwpmc_defs.vh"
module iwpmc_ctrl_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic bnd = 1'b0;
  logic [4:0] ops = 5'h00;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [5:0] pins = 6'h00;
  logic lvd = 1'b1;
  logic tcmp = 1'b0;
  logic [31:0] rng = 32'h3;
  wire [31:0] rdata;
  wire [10:0] vaddr;
  wire [7:0] t0;
  wire [9:0] t1;
  wire wreq, vl, run, per, tmr, fosc, sosc, sfast, div4, wclr, global_irq_enable, wdt, ovf;
  int miscompares = 0;
  int checked = 0;
  int pend = 0;
  int en = 0;
  int gie_m = 0;
  int vl_cnt = 0;
  int wc_cnt = 0;

  // Clock at 250 MHz
  initial begin
    forever #2 clk = ~clk;
  end

  iwpmc_ctrl u_iwpmc_ctrl (.i_ref_clk(clk), .i_srst(srst), .i_ce(1'b1),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_instr_boundary(bnd), .i_op_trap(ops[0]), .i_op_enable(ops[1]), .i_op_mask(ops[2]),
    .i_op_return(ops[3]), .i_op_sleep(ops[4]), .i_timer0_count(t0), .i_timer1_count(t1),
    .i_wdt_timeout(wdt), .i_pin_is_input(6'h3F), .i_port_pin(pins), .i_lvd_out(lvd),
    .i_touch_compare_out(tcmp), .i_touch_overflow(ovf), .o_vector_load(vl),
    .o_vector_addr(vaddr), .o_exec_run(run), .o_periph_enable(per), .o_timer_enable(tmr),
    .o_fast_rc_osc_en(fosc), .o_slow_rc_osc_en(sosc), .o_sys_clk_fast(sfast),
    .o_inst_div4(div4), .o_wdt_clear(wclr), .o_global_irq_enable(global_irq_enable));

  iwpmc_periph_model u_iwpmc_periph_model (.i_ref_clk(clk), .i_go(go), .i_kind(kind),
    .i_timer_en(tmr), .o_t0(t0), .o_t1(t1), .o_wdt(wdt), .o_ovf(ovf));

  // Pulse counters
  always @(posedge clk) begin
    if (vl === 1'b1) vl_cnt++;
    if (wclr === 1'b1) wc_cnt++;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic stop_test;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 40) chk(wreq, 0);
  endtask

  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask

  // Event k sets flag bit k; async lines pulse for one cycle, except pin 1, which toggles
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      2: pins[1] <= ~pins[1];
      3: pins[0] <= 1'b1;
      4: lvd <= 1'b0;
      5: tcmp <= 1'b1;
      default: begin
        go <= 1'b1;
        kind <= k[2:0];
      end
    endcase
    @(posedge clk);
    go <= 1'b0;
    pins[0] <= 1'b0;
    lvd <= 1'b1;
    tcmp <= 1'b0;
    pend = pend | (1 << k);
  endtask

  // Op k: 0 trap, 1 enable, 2 mask, 3 return, 4 sleep, 5 bare boundary
  task automatic op(input int k);
    logic v;
    logic [10:0] va;
    v = 1'b0;
    va = vaddr;
    @(posedge clk);
    bnd <= 1'b1;
    ops <= (k < 5) ? (5'h01 << k) : 5'h00;
    @(posedge clk);
    bnd <= 1'b0;
    ops <= 5'h00;
    if (k == 0) begin
      v = 1'b1;
      va = `IWPMC_VEC_SOFT;
      gie_m = 0;
    end else if (k == 2) gie_m = 0;
    else if (gie_m != 0 && (pend & en) != 0) begin
      v = 1'b1;
      va = `IWPMC_VEC_HARD;
      gie_m = 0;
    end else if (k == 1 || k == 3) gie_m = 1;
    #1;
    chk({19'h0, global_irq_enable, vl, vaddr}, {19'h0, gie_m[0], v, va});
  endtask

  // Hang guard, far beyond the sequence length
  initial begin
    #200000;
    miscompares++;
    stop_test;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n;
    int q0;
    cyc(8);
    srst <= 1'b0;
    cyc(3);
    chk({30'h0, run, sfast}, 32'h3);
    rdc(`IWPMC_OFF_STATUS, 32'h01, 32'h0F);
    wrr(`IWPMC_OFF_CONFIG, 8'h05);
    wrr(`IWPMC_OFF_PINCFG, 8'hC3);
    wrr(`IWPMC_OFF_ENABLE, 8'hFF);
    en = 255;
    for (int k = 0; k < 8; k++) begin
      fire(k);
      cyc(6);
      rdc(`IWPMC_OFF_PENDING, 1 << k, 32'hFF);
      wrr(`IWPMC_OFF_PENDING, 8'h00);
      pend = 0;
    end
    // Watchdog in reset action raises no flag
    wrr(`IWPMC_OFF_CONFIG, 8'h04);
    fire(6);
    cyc(4);
    pend = 0;
    rdc(`IWPMC_OFF_PENDING, 32'h0, 32'hFF);
    wrr(`IWPMC_OFF_CONFIG, 8'h05);
    wrr(`IWPMC_OFF_PINCFG, 8'h43);
    for (int k = 0; k < 8; k++) fire(k);
    cyc(6);
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      en = rng[7:0];
      wrr(`IWPMC_OFF_ENABLE, rng[7:0]);
      rdc(`IWPMC_OFF_PENDING, pend & en, 32'hFF);
    end
    rdc(5'h18, 32'h0, 32'hFFFFFFFF);
    wrr(`IWPMC_OFF_ENABLE, 8'hFF);
    en = 255;
    rdc(`IWPMC_OFF_PENDING, 32'hFF, 32'hFF);
    wrr(`IWPMC_OFF_PENDING, 8'h00);
    pend = 0;
    op(0); op(3); op(0); op(1); op(2); op(1);
    q0 = vl_cnt;
    fire(0);
    cyc(6);
    chk(vl_cnt, q0);
    op(5);
    wrr(`IWPMC_OFF_PENDING, 8'h00);
    pend = 0;
    // Clock select, divider, fast oscillator stop
    wrr(`IWPMC_OFF_CONFIG, 8'h07);
    cyc(2);
    chk(div4, 1);
    wrr(`IWPMC_OFF_OSC, 8'h03);
    cyc(2);
    chk({sfast, fosc}, 2'b11);
    wrr(`IWPMC_OFF_OSC, 8'h00);
    cyc(2);
    chk({div4, sfast, fosc}, 3'b101);
    rdc(`IWPMC_OFF_STATUS, 32'h02, 32'h07);
    wrr(`IWPMC_OFF_OSC, 8'h02);
    cyc(2);
    chk({sfast, fosc}, 2'b00);
    wrr(`IWPMC_OFF_OSC, 8'h01);
    cyc(2);
    chk({sfast, fosc}, 2'b11);
    // Standby, woken by a timer with interrupts masked
    wrr(`IWPMC_OFF_OSC, 8'h09);
    cyc(2);
    chk({run, per, tmr, sosc, fosc}, 5'h07);
    q0 = vl_cnt;
    fire(0);
    n = 0;
    while (run !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    cyc(4);
    chk({n < 8, vl_cnt == q0, sfast}, 3'b111);
    wrr(`IWPMC_OFF_PENDING, 8'h00);
    pend = 0;
    // Halt, entered by sleep op and by mode write
    for (int j = 0; j < 2; j++) begin
      op(1);
      if (j == 0) op(4);
      else wrr(`IWPMC_OFF_OSC, 8'h05);
      cyc(3);
      chk({run, per, tmr, fosc, sosc}, 5'h00);
      rdc(`IWPMC_OFF_STATUS, 32'h2C, 32'h3F);
      chk(wc_cnt, j + 1);
      fire(4);
      cyc(20);
      chk(run, 0);
      fire(6);
      n = 0;
      while (run !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      chk(n >= 16 && n < 30, 1);
      cyc(4);
      op(5);
      chk({global_irq_enable, vaddr}, {1'b0, `IWPMC_VEC_HARD});
      gie_m = 0;
      wrr(`IWPMC_OFF_PENDING, 8'h00);
      pend = 0;
    end
    stop_test;
  end
endmodule

// file: testbench/iwpmc_ctrl_monitor.sv
// Concurrent checks on the controller ports
`timescale 1ns/100ps
`include "iwpmc_defs.vh"
module iwpmc_ctrl_monitor (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire i_instr_boundary,
  input wire i_op_trap,
  input wire i_op_enable,
  input wire i_op_mask,
  input wire o_vector_load,
  input wire [10:0] o_vector_addr,
  input wire o_exec_run,
  input wire o_periph_enable,
  input wire o_timer_enable,
  input wire o_fast_rc_osc_en,
  input wire o_slow_rc_osc_en,
  input wire o_sys_clk_fast,
  input wire o_wdt_clear,
  input wire o_global_irq_enable
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  property p_trap; i_instr_boundary && i_op_trap && o_exec_run |=> o_vector_load
    && o_vector_addr == `IWPMC_VEC_SOFT && !o_global_irq_enable; endproperty
  a_trap: assert property (p_trap) else $error("trap not vectored");
  property p_enable; i_instr_boundary && i_op_enable && !i_op_trap && !i_op_mask
    && o_exec_run && !o_global_irq_enable |=> o_global_irq_enable; endproperty
  a_enable: assert property (p_enable) else $error("enable op ignored");
  property p_mask; i_instr_boundary && i_op_mask && !i_op_trap && o_exec_run
    |=> !o_global_irq_enable && !o_vector_load; endproperty
  a_mask: assert property (p_mask) else $error("mask op ignored");
  property p_hw; o_vector_load && o_vector_addr == `IWPMC_VEC_HARD
    |-> !o_global_irq_enable && $past(o_global_irq_enable); endproperty
  a_hw: assert property (p_hw) else $error("hardware vector without enable");
  property p_halt; !o_slow_rc_osc_en |-> !o_exec_run && !o_periph_enable
    && !o_timer_enable && !o_fast_rc_osc_en; endproperty
  a_halt: assert property (p_halt) else $error("halt left logic running");
  property p_wdt; o_wdt_clear |-> ##[1:2] (!o_slow_rc_osc_en && !o_wdt_clear); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear outside halt");
  property p_sysclk; o_sys_clk_fast && o_exec_run |-> o_fast_rc_osc_en; endproperty
  a_sysclk: assert property (p_sysclk) else $error("running on stopped clock");
  property p_bus; i_ce && (i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest; endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");
endmodule

bind iwpmc_ctrl iwpmc_ctrl_monitor u_iwpmc_ctrl_monitor (.i_ref_clk(i_ref_clk),
  .i_srst(i_srst), .i_ce(i_ce), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .i_instr_boundary(i_instr_boundary),
  .i_op_trap(i_op_trap), .i_op_enable(i_op_enable), .i_op_mask(i_op_mask),
  .o_vector_load(o_vector_load), .o_vector_addr(o_vector_addr), .o_exec_run(o_exec_run),
  .o_periph_enable(o_periph_enable), .o_timer_enable(o_timer_enable),
  .o_fast_rc_osc_en(o_fast_rc_osc_en), .o_slow_rc_osc_en(o_slow_rc_osc_en),
  .o_sys_clk_fast(o_sys_clk_fast), .o_wdt_clear(o_wdt_clear),
  .o_global_irq_enable(o_global_irq_enable));

// file: testbench/iwpmc_periph_model.sv
// Behavioural model of the timer, watchdog and touch event sources
`timescale 1ns/100ps
module iwpmc_periph_model (
  input wire i_ref_clk,
  input wire i_go,
  input wire [2:0] i_kind,
  input wire i_timer_en,
  output logic [7:0] o_t0 = 8'h80,
  output logic [9:0] o_t1 = 10'h100,
  output logic o_wdt = 1'b0,
  output logic o_ovf = 1'b0
);
  // One-cycle event pulses, as the real sources give them
  always @(posedge i_ref_clk) begin
    o_wdt <= i_go && i_kind == 3'h6;
    o_ovf <= i_go && i_kind == 3'h7;
  end

  // Counters idle mid-range and freeze while the timers are gated off
  always @(posedge i_ref_clk) begin
    if (i_timer_en) begin
      o_t0 <= (i_go && i_kind == 3'h0) ? 8'hFF : (o_t0 == 8'hFF) ? 8'h00 : 8'h80;
      o_t1 <= (i_go && i_kind == 3'h1) ? 10'h000 : (o_t1 == 10'h000) ? 10'h3FF : 10'h100;
    end
  end
endmodule
